/* File: hdl/freq_protection_unit.sv */
// top of the eight-stage frequency protection unit
`timescale 1ns/1ps
`default_nettype none
module freq_protection_unit
  import freq_prot_pkg::*;
#(
  parameter int CYCLE_CLKS = CYC_CLKS, // processing cycle length
  parameter int MS_CLKS = TS_CLKS // time stamp tick length
)(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [FW-1:0] freqIn,
  input wire logic blockIn,
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [NST-1:0] startOut,
  output logic [NST-1:0] tripOut,
  output logic [NST-1:0] blockedOut,
  output logic blockNotify,
  output logic evtValid,
  output logic [5:0] evtCode,
  output logic [31:0] evtTime,
  output logic [FW-1:0] evtFreq
);
  localparam int NSIG = 3 * NST; // start, trip, block per stage

  // two-flop sync of the blocking matrix pin
  logic blkMeta_reg;
  logic blkSync_reg;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      blkMeta_reg <= 1'b0;
      blkSync_reg <= 1'b0;
    end else begin
      blkMeta_reg <= blockIn;
      blkSync_reg <= blkMeta_reg;
    end
  end

  // processing cycle tick
  logic [31:0] cycCnt_reg;
  logic tick;
  assign tick = cycCnt_reg == 32'(CYCLE_CLKS - 1);
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cycCnt_reg <= '0;
    end else begin
      cycCnt_reg <= tick ? '0 : cycCnt_reg + 32'h1;
    end
  end

  // millisecond time stamp
  logic [31:0] msDiv_reg;
  logic [31:0] msTime_reg;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      msDiv_reg <= '0;
      msTime_reg <= '0;
    end else if (msDiv_reg == 32'(MS_CLKS - 1)) begin
      msDiv_reg <= '0;
      msTime_reg <= msTime_reg + 32'h1;
    end else begin
      msDiv_reg <= msDiv_reg + 32'h1;
    end
  end

  // bus handshake: one wait cycle per access
  logic waitReq_reg;
  logic acc;
  logic wr;
  assign acc = (avs_read || avs_write) && waitReq_reg;
  assign wr = avs_write && !waitReq_reg; // write lands on the answer edge
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      waitReq_reg <= 1'b1;
    end else begin
      waitReq_reg <= !acc;
    end
  end
  assign avs_waitrequest = waitReq_reg;

  // control registers
  logic forceEn_reg; // stage forcing mode
  logic swBlk_reg; // software block switch
  logic [2:0] grp_reg; // active setting group
  logic [2:0] mode_reg; // logical node mode
  logic [5:0] evSel_reg; // event on/off selection
  logic [2*NST-1:0] force_reg; // forced status
  logic [2:0] infoSel_reg; // stage shown in info
  logic [4:0] cntSel_reg;
  logic [3:0] recSel_reg;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      forceEn_reg <= 1'b0;
      swBlk_reg <= 1'b0;
      grp_reg <= '0;
      mode_reg <= LN_ON;
      evSel_reg <= EVSEL_RST;
      force_reg <= '0;
      infoSel_reg <= '0;
      cntSel_reg <= '0;
      recSel_reg <= '0;
    end else if (wr) begin
      unique case (avs_address)
        A_CTRL: begin
          forceEn_reg <= avs_writedata[CTRL_FEN];
          swBlk_reg <= avs_writedata[CTRL_SWB];
          grp_reg <= avs_writedata[CTRL_GRP +: 3];
          if (avs_writedata[CTRL_MODE +: 3] >= LN_ON && avs_writedata[CTRL_MODE +: 3] <= LN_OFF) begin
            mode_reg <= avs_writedata[CTRL_MODE +: 3];
          end
        end
        A_EVSEL: evSel_reg <= avs_writedata[5:0];
        A_FORCE: force_reg <= avs_writedata[2*NST-1:0];
        A_INFO: infoSel_reg <= avs_writedata[2:0];
        A_CNTSEL: cntSel_reg <= avs_writedata[4:0];
        A_RECSEL: recSel_reg <= (avs_writedata[3:0] < 4'(NREC)) ? avs_writedata[3:0] : 4'(NREC - 1);
        default: ;
      endcase
    end
  end

  // per-group settings, window at address bit 10
  logic [NST-1:0] setEn_reg [NGRP];
  logic [FW-1:0] setPu_reg [NGRP][NST];
  logic [DW-1:0] setDly_reg [NGRP][NST];
  logic setHit;
  logic [2:0] aGrp;
  logic [2:0] aSt;
  logic [1:0] aFld;
  assign setHit = avs_address[10] && avs_address[1:0] == 2'h0;
  assign aGrp = avs_address[9:7];
  assign aSt = avs_address[6:4];
  assign aFld = avs_address[3:2];
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int g = 0; g < NGRP; g++) begin
        setEn_reg[g] <= '0;
        for (int s = 0; s < NST; s++) begin
          setPu_reg[g][s] <= (s < NST / 2) ? PU_OVER_RST : PU_UNDER_RST;
          setDly_reg[g][s] <= DLY_RST;
        end
      end
    end else if (wr && setHit) begin
      unique case (aFld)
        2'h0: setEn_reg[aGrp][aSt] <= avs_writedata[0];
        2'h1: setPu_reg[aGrp][aSt] <= avs_writedata[FW-1:0];
        2'h2: setDly_reg[aGrp][aSt] <= avs_writedata[DW-1:0];
        default: ;
      endcase
    end
  end

  // effective block: pin, test switch, node mode
  logic modeBlk;
  logic blkEff;
  assign modeBlk = mode_reg == LN_BLK || mode_reg == LN_TBLK;
  assign blkEff = blkSync_reg || (forceEn_reg && swBlk_reg) || modeBlk;

  // eight stage engines, block latched at tick
  stage_if sif [NST] ();
  logic [NST-1:0] stStart;
  logic [NST-1:0] stTrip;
  logic [NST-1:0] stBlk;
  logic [DW-1:0] leftV [NST];
  for (genvar s = 0; s < NST; s++) begin : g_st
    assign sif[s].en = setEn_reg[grp_reg][s] && mode_reg != LN_OFF;
    assign sif[s].under = s >= NST / 2;
    assign sif[s].pickup = setPu_reg[grp_reg][s];
    assign sif[s].delay = setDly_reg[grp_reg][s];
    assign stStart[s] = sif[s].start;
    assign stTrip[s] = sif[s].trip;
    assign stBlk[s] = sif[s].blocked;
    assign leftV[s] = sif[s].left;
    freq_stage u_st (
      .core_clk(core_clk),
      .nrst(nrst),
      .tick(tick),
      .blk(blkEff),
      .freq(freqIn),
      .st(sif[s])
    );
  end

  // stage condition with forcing override
  logic [1:0] cond [NST];
  logic [NSIG-1:0] sigNext;
  always_comb begin
    for (int s = 0; s < NST; s++) begin
      if (forceEn_reg) begin
        cond[s] = force_reg[2*s +: 2];
      end else if (stTrip[s]) begin
        cond[s] = COND_TRIP;
      end else if (stStart[s]) begin
        cond[s] = COND_START;
      end else if (stBlk[s]) begin
        cond[s] = COND_BLK;
      end else begin
        cond[s] = COND_NORM;
      end
      sigNext[3*s] = cond[s] == COND_START || cond[s] == COND_TRIP;
      sigNext[3*s+1] = cond[s] == COND_TRIP;
      sigNext[3*s+2] = cond[s] == COND_BLK;
    end
  end

  // registered outputs and pending edge events
  logic [NSIG-1:0] sig_reg;
  logic [NSIG-1:0] pendOn_reg;
  logic [NSIG-1:0] pendOff_reg;
  logic [NSIG-1:0] chg;
  logic [NSIG-1:0] gMask;
  logic gValid;
  logic gDir; // 1 = ON edge
  logic [4:0] gIdx;
  assign chg = sigNext ^ sig_reg;
  always_comb begin
    gIdx = '0;
    gDir = 1'b0;
    gValid = 1'b0;
    for (int i = NSIG - 1; i >= 0; i--) begin
      if (pendOff_reg[i]) begin
        gIdx = 5'(i);
        gValid = 1'b1;
      end
    end
    for (int i = NSIG - 1; i >= 0; i--) begin
      if (pendOn_reg[i]) begin
        gIdx = 5'(i);
        gDir = 1'b1;
        gValid = 1'b1;
      end
    end
  end
  assign gMask = gValid ? (NSIG'(1) << gIdx) : '0;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sig_reg <= '0;
      pendOn_reg <= '0;
      pendOff_reg <= '0;
    end else begin
      sig_reg <= sigNext;
      pendOn_reg <= (pendOn_reg & ~(gDir ? gMask : '0)) | (chg & sigNext);
      pendOff_reg <= (pendOff_reg & ~(gDir ? '0 : gMask)) | (chg & ~sigNext);
    end
  end
  for (genvar s = 0; s < NST; s++) begin : g_out
    assign startOut[s] = sig_reg[3*s];
    assign tripOut[s] = sig_reg[3*s+1];
    assign blockedOut[s] = sig_reg[3*s+2];
  end

  // stamp and frequencies of the latest change
  logic [FW-1:0] hist_reg [PRE_CYC];
  logic [31:0] tsLatch_reg;
  logic [FW-1:0] fltLatch_reg;
  logic [FW-1:0] preLatch_reg;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < PRE_CYC; i++) begin
        hist_reg[i] <= '0;
      end
      tsLatch_reg <= '0;
      fltLatch_reg <= '0;
      preLatch_reg <= '0;
    end else begin
      if (tick) begin
        hist_reg[0] <= freqIn;
        for (int i = 1; i < PRE_CYC; i++) begin
          hist_reg[i] <= hist_reg[i-1];
        end
      end
      if (|chg) begin
        tsLatch_reg <= msTime_reg;
        fltLatch_reg <= freqIn;
        preLatch_reg <= hist_reg[PRE_CYC-1];
      end
    end
  end

  // event port, one granted edge per clock
  logic [2:0] gSt;
  logic [1:0] gType;
  assign gSt = 3'(gIdx / 5'h3);
  assign gType = 2'(gIdx % 5'h3);
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      evtValid <= 1'b0;
      evtCode <= '0;
      evtTime <= '0;
      evtFreq <= '0;
      blockNotify <= 1'b0;
    end else begin
      evtValid <= gValid && evSel_reg[{gType, gDir}];
      evtCode <= {gSt, gType, gDir};
      evtTime <= tsLatch_reg;
      evtFreq <= fltLatch_reg;
      blockNotify <= |blockedOut;
    end
  end

  // ring of the twelve latest ON records
  logic [3:0] wrPtr_reg;
  logic [31:0] recTime [NREC];
  logic [5:0] recCode [NREC];
  logic [2:0] recGrp [NREC];
  logic [FW-1:0] recPre [NREC];
  logic [FW-1:0] recFlt [NREC];
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wrPtr_reg <= '0;
      for (int i = 0; i < NREC; i++) begin
        recTime[i] <= '0;
        recCode[i] <= '0;
        recGrp[i] <= '0;
        recPre[i] <= '0;
        recFlt[i] <= '0;
      end
    end else if (gValid && gDir) begin
      recTime[wrPtr_reg] <= tsLatch_reg;
      recCode[wrPtr_reg] <= {gSt, gType, gDir};
      recGrp[wrPtr_reg] <= grp_reg;
      recPre[wrPtr_reg] <= preLatch_reg;
      recFlt[wrPtr_reg] <= fltLatch_reg;
      wrPtr_reg <= (wrPtr_reg == 4'(NREC - 1)) ? '0 : wrPtr_reg + 4'h1;
    end
  end
  logic [4:0] rp0;
  logic [3:0] rp;
  assign rp0 = 5'(wrPtr_reg) + 5'(NREC - 1) - 5'(recSel_reg);
  assign rp = (rp0 >= 5'(NREC)) ? 4'(rp0 - 5'(NREC)) : rp0[3:0];

  // occurrence counters, set wins over clear
  logic [15:0] cnt_reg [NSIG];
  logic [NSIG-1:0] clrV;
  assign clrV = (wr && avs_address == A_CNTCLR) ? avs_writedata[NSIG-1:0] : '0;
  for (genvar i = 0; i < NSIG; i++) begin : g_cnt
    always_ff @(posedge core_clk) begin
      if (!nrst) begin
        cnt_reg[i] <= '0;
      end else if (gDir && gMask[i]) begin
        cnt_reg[i] <= clrV[i] ? 16'h1 : cnt_reg[i] + 16'h1;
      end else if (clrV[i]) begin
        cnt_reg[i] <= '0;
      end
    end
  end

  // ratio of measured to pickup frequency
  logic [FW-1:0] selPu;
  logic [FW+9:0] num;
  logic [FW+9:0] ratio_reg;
  assign selPu = setPu_reg[grp_reg][infoSel_reg];
  assign num = (FW+10)'(freqIn) * RATIO_SCALE;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ratio_reg <= '0;
    end else begin
      ratio_reg <= (selPu == '0) ? '0 : num / (FW+10)'(selPu);
    end
  end

  // read data mux
  logic [31:0] rdMux;
  always_comb begin
    rdMux = '0;
    if (setHit) begin
      unique case (aFld)
        2'h0: rdMux[0] = setEn_reg[aGrp][aSt];
        2'h1: rdMux[FW-1:0] = setPu_reg[aGrp][aSt];
        2'h2: rdMux[DW-1:0] = setDly_reg[aGrp][aSt];
        default: ;
      endcase
    end else begin
      unique case (avs_address)
        A_CTRL: begin
          rdMux[CTRL_FEN] = forceEn_reg;
          rdMux[CTRL_SWB] = swBlk_reg;
          rdMux[CTRL_GRP +: 3] = grp_reg;
          rdMux[CTRL_MODE +: 3] = mode_reg;
        end
        A_EVSEL: rdMux[5:0] = evSel_reg;
        A_FORCE: rdMux[2*NST-1:0] = force_reg;
        A_STAT: begin
          for (int s = 0; s < NST; s++) begin
            rdMux[2*s +: 2] = cond[s];
          end
          rdMux[STAT_BEH +: 3] = mode_reg;
        end
        A_INFO: rdMux[2:0] = infoSel_reg;
        A_RATIO: rdMux[FW+9:0] = ratio_reg;
        A_REMAIN: rdMux[DW-1:0] = leftV[infoSel_reg];
        A_EXPECT: rdMux[DW-1:0] = selDly();
        A_CNTSEL: rdMux[4:0] = cntSel_reg;
        A_CNT: rdMux[15:0] = (cntSel_reg < 5'(NSIG)) ? cnt_reg[cntSel_reg] : '0;
        A_RECSEL: rdMux[3:0] = recSel_reg;
        A_RTIME: rdMux = recTime[rp];
        A_RINFO: begin
          rdMux[5:0] = recCode[rp];
          rdMux[RINFO_GRP +: 3] = recGrp[rp];
        end
        A_RPRE: rdMux[FW-1:0] = recPre[rp];
        A_RFLT: rdMux[FW-1:0] = recFlt[rp];
        A_TIME: rdMux = msTime_reg;
        default: ;
      endcase
    end
  end
  function automatic logic [DW-1:0] selDly();
    return setDly_reg[grp_reg][infoSel_reg];
  endfunction
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      avs_readdata <= '0;
    end else if (acc && avs_read) begin
      avs_readdata <= rdMux;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_bus_answer: assert property (acc |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
  a_event_drain: assert property ($rose(pendOn_reg[0]) |-> ##[1:48] !pendOn_reg[0])
    else $error("event never issued");
  a_force_block: assert property (forceEn_reg && force_reg[1:0] == COND_BLK
    |=> blockedOut[0] && !startOut[0])
    else $error("forced block not shown");
endmodule // freq_protection_unit
`default_nettype wire

/* File: inc/freq_prot_pkg.sv */
// shared constants for the frequency protection unit
package freq_prot_pkg;
  localparam int NST = 8; // stages: 0..3 over, 4..7 under
  localparam int NGRP = 8; // setting groups
  localparam int FW = 17; // frequency width, unit 1 mHz
  localparam int DW = 19; // delay width, unit 5 ms
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_MS = 5; // processing cycle in ms
  localparam int CYC_CLKS = CLK_HZ / 1000 * CYC_MS;
  localparam int TS_MS = 1; // time stamp step in ms
  localparam int TS_CLKS = CLK_HZ / 1000 * TS_MS;
  localparam int PRE_MS = 20; // pre-trigger look-back
  localparam int PRE_CYC = PRE_MS / CYC_MS;
  localparam int NREC = 12; // operation records kept
  localparam logic [FW-1:0] HYST_MHZ = 17'h00014; // 20 mHz
  localparam logic [FW-1:0] PU_OVER_RST = 17'h0C738; // 51.00 Hz
  localparam logic [FW-1:0] PU_UNDER_RST = 17'h0BF68; // 49.00 Hz
  localparam logic [DW-1:0] DLY_RST = 19'h00014; // 0.1 s
  localparam logic [FW+9:0] RATIO_SCALE = 27'h00003E8; // 0.001 steps
  // logical node modes and stage conditions
  localparam logic [2:0] LN_ON = 3'h1;
  localparam logic [2:0] LN_BLK = 3'h2;
  localparam logic [2:0] LN_TEST = 3'h3;
  localparam logic [2:0] LN_TBLK = 3'h4;
  localparam logic [2:0] LN_OFF = 3'h5;
  localparam logic [1:0] COND_NORM = 2'h0;
  localparam logic [1:0] COND_START = 2'h1;
  localparam logic [1:0] COND_TRIP = 2'h2;
  localparam logic [1:0] COND_BLK = 2'h3;
  // register byte addresses
  localparam logic [10:0] A_CTRL = 11'h000;
  localparam logic [10:0] A_EVSEL = 11'h004;
  localparam logic [10:0] A_FORCE = 11'h008;
  localparam logic [10:0] A_STAT = 11'h00C;
  localparam logic [10:0] A_INFO = 11'h010;
  localparam logic [10:0] A_RATIO = 11'h014;
  localparam logic [10:0] A_REMAIN = 11'h018;
  localparam logic [10:0] A_EXPECT = 11'h01C;
  localparam logic [10:0] A_CNTCLR = 11'h020;
  localparam logic [10:0] A_CNTSEL = 11'h024;
  localparam logic [10:0] A_CNT = 11'h028;
  localparam logic [10:0] A_RECSEL = 11'h02C;
  localparam logic [10:0] A_RTIME = 11'h030;
  localparam logic [10:0] A_RINFO = 11'h034;
  localparam logic [10:0] A_RPRE = 11'h038;
  localparam logic [10:0] A_RFLT = 11'h03C;
  localparam logic [10:0] A_TIME = 11'h040;
  // control fields and reset values
  localparam int CTRL_FEN = 0;
  localparam int CTRL_SWB = 1;
  localparam int CTRL_GRP = 4;
  localparam int CTRL_MODE = 8;
  localparam int STAT_BEH = 16;
  localparam int RINFO_GRP = 8;
  localparam logic [5:0] EVSEL_RST = 6'h3F;
endpackage

/* File: inc/stage_if.sv */
// settings and results of one protection stage
`timescale 1ns/1ps
`default_nettype none
interface stage_if;
  import freq_prot_pkg::*;
  logic en; // stage active
  logic under; // underfrequency stage
  logic [FW-1:0] pickup; // setting, mHz
  logic [DW-1:0] delay; // operate delay, 5 ms steps
  logic start;
  logic trip;
  logic blocked;
  logic [DW-1:0] left; // time to trip
  modport core (input en, under, pickup, delay, output start, trip, blocked, left);
  modport ctl (output en, under, pickup, delay, input start, trip, blocked, left);
endinterface
`default_nettype wire

/* File: hdl/freq_stage.sv */
// one definite-time frequency stage
`timescale 1ns/1ps
`default_nettype none
module freq_stage
  import freq_prot_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic blk,
  input wire logic [FW-1:0] freq,
  stage_if.core st
);
  logic picked_reg; // comparator state
  logic start_reg;
  logic trip_reg;
  logic blk_reg;
  logic [DW-1:0] cnt_reg; // operate timer
  logic pickNext;
  logic runNext;

  // threshold with hysteresis once picked up
  assign pickNext = !st.en ? 1'b0 :
    st.under ? (freq < (picked_reg ? st.pickup + HYST_MHZ : st.pickup)) :
    (freq > (picked_reg ? st.pickup - HYST_MHZ : st.pickup));
  assign runNext = pickNext && !blk;

  // comparator and gated outputs, once per cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      picked_reg <= 1'b0;
      start_reg <= 1'b0;
      blk_reg <= 1'b0;
    end else if (tick) begin
      picked_reg <= pickNext;
      start_reg <= runNext;
      blk_reg <= pickNext && blk;
    end
  end

  // definite-time timer, cleared on any drop
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      trip_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (tick) begin
      if (runNext) begin
        trip_reg <= cnt_reg >= st.delay;
        if (cnt_reg < st.delay) begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end else begin
        trip_reg <= 1'b0;
        cnt_reg <= '0;
      end
    end
  end

  assign st.start = start_reg;
  assign st.trip = trip_reg;
  assign st.blocked = blk_reg;
  assign st.left = (start_reg && !trip_reg) ? st.delay - cnt_reg : '0;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_trip_has_start: assert property (trip_reg |-> start_reg)
    else $error("trip without start");
  a_block_no_run: assert property (blk_reg |-> !start_reg && !trip_reg)
    else $error("blocked stage running");
  a_trip_timed: assert property ($rose(trip_reg) && st.delay != '0 |-> $past(start_reg))
    else $error("trip not preceded by start");
  a_disabled_idle: assert property (tick && !st.en |=> !start_reg && !blk_reg)
    else $error("disabled stage active");
  a_over_pick: assert property (tick && st.en && !st.under && !blk && freq > st.pickup
    |=> start_reg)
    else $error("over stage missed pickup");
  a_hyst_hold: assert property (tick && st.en && st.under && picked_reg && !blk
    && freq < st.pickup + HYST_MHZ |=> start_reg)
    else $error("under stage dropped inside band");
endmodule // freq_stage
`default_nettype wire

/* File: bench/freq_front_end.sv */
// model of the frequency front end and blocking matrix
`timescale 1ns/1ps
`default_nettype none
module freq_front_end
  import freq_prot_pkg::*;
(
  input wire logic core_clk,
  input wire logic [FW-1:0] freqSet, // wanted frequency, mHz
  input wire logic blkSet, // wanted block level
  output logic [FW-1:0] freqIn, // processed frequency
  output logic blockIn // dedicated block line
);
  // sane levels before the first edge
  initial begin
    freqIn = 17'h0C350;
    blockIn = 1'b0;
  end
  // block held whole ticks, well before any delay ends
  always @(posedge core_clk) begin
    freqIn <= freqSet;
    blockIn <= blkSet;
  end
endmodule // freq_front_end
`default_nettype wire

/* File: bench/freq_protection_unit_tb.sv */
// self-checking bench of the frequency protection unit
`timescale 1ns/1ps
`default_nettype none
module freq_protection_unit_tb;
  import freq_prot_pkg::*;
  logic core_clk, nrst, avs_read, avs_write, avs_waitrequest, blockNotify, evtValid;
  logic blkSet, blockIn; // block request and line
  logic [10:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, evtTime, q, seed;
  logic [31:0] lastT = 32'h0; // stamp of the previous event
  logic [NST-1:0] startOut, tripOut, blockedOut;
  logic [5:0] evtCode;
  logic [FW-1:0] freqSet, freqIn, evtFreq;
  int errors, comparisons;
  logic [5:0] expQ[$]; // expected event codes, oldest first
  freq_front_end i_src (.core_clk(core_clk), .freqSet(freqSet), .blkSet(blkSet),
    .freqIn(freqIn), .blockIn(blockIn));
  freq_protection_unit #(.CYCLE_CLKS(20), .MS_CLKS(4)) i_dut (.core_clk(core_clk),
    .nrst(nrst), .freqIn(freqIn), .blockIn(blockIn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .startOut(startOut),
    .tripOut(tripOut), .blockedOut(blockedOut), .blockNotify(blockNotify),
    .evtValid(evtValid), .evtCode(evtCode), .evtTime(evtTime), .evtFreq(evtFreq));
  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // xorshift source
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // one output bit: 0 start, 1 trip, 2 blocked
  function logic pick(input int k, input int i);
    return (k == 0) ? startOut[i] : (k == 1) ? tripOut[i] : blockedOut[i];
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [10:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) errors++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [10:0] a, input logic [31:0] e);
    bus(1'b0, a, xs());
    chk(nm, e, q);
  endtask
  task automatic tk(input int n); // whole processing ticks
    repeat (n * 20) @(posedge core_clk);
  endtask
  task automatic wait_hi(input int k, input int i);
    int n;
    n = 0;
    while (pick(k, i) !== 1'b1 && n < 600) begin
      @(posedge core_clk);
      n++;
    end
    chk("output rise", 32'h1, {31'h0, pick(k, i)});
  endtask
  // event watcher: oldest note against each pulse
  always @(posedge core_clk) begin
    if (evtValid === 1'b1) begin
      if (expQ.size() == 0) chk("event", 32'hFFFFFFFF, {26'h0, evtCode});
      else chk("event", {26'h0, expQ.pop_front()}, {26'h0, evtCode});
      chk("event freq", {15'h0, freqSet}, {15'h0, evtFreq});
      chk("event time", 32'h1, {31'h0, evtTime >= lastT && evtTime != 32'h0});
      lastT <= evtTime;
    end
  end
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, run needs about 1600 clocks
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    {nrst, avs_read, avs_write, blkSet} = 4'h0;
    avs_address = 11'h000;
    avs_writedata = 32'h0;
    freqSet = 17'h0C350;
    seed = 32'd59844;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd("ctrl", A_CTRL, 32'h00000100);
    rd("evsel", A_EVSEL, 32'h0000003F);
    rd("enable", 11'h400, 32'h0);
    rd("pickup over", 11'h404, 32'h0000C738);
    rd("pickup under", 11'h444, 32'h0000BF68);
    rd("delay", 11'h408, 32'h00000014);
    rd("unmapped", 11'h3F0, 32'h0);
    // disabled stage ignores overfrequency
    freqSet <= 17'h0CB20;
    tk(3);
    chk("start", 32'h0, {24'h0, startOut});
    freqSet <= 17'h0C738;
    wr(11'h408, 32'h2);
    wr(11'h400, 32'h1);
    tk(3);
    chk("start", 32'h0, {24'h0, startOut});
    expQ.push_back(6'h01);
    freqSet <= 17'h0C739;
    wait_hi(0, 0);
    expQ.push_back(6'h03);
    repeat (38) @(posedge core_clk);
    chk("trip", 32'h0, {31'h0, tripOut[0]});
    repeat (3) @(posedge core_clk);
    chk("trip", 32'h1, {31'h0, tripOut[0]});
    freqSet <= 17'(50981 + xs() % 19);
    tk(3);
    chk("start", 32'h1, {31'h0, startOut[0]});
    expQ.push_back(6'h00);
    expQ.push_back(6'h02);
    freqSet <= 17'h0C724;
    tk(2);
    chk("start", 32'h0, {24'h0, startOut});
    // block after start, then block before pickup
    wr(11'h408, 32'h64);
    expQ.push_back(6'h01);
    freqSet <= 17'h0C92C;
    wait_hi(0, 0);
    expQ.push_back(6'h05);
    expQ.push_back(6'h00);
    blkSet <= 1'b1;
    tk(2);
    chk("blocked start", 32'h0100, {16'h0, blockedOut, startOut});
    chk("notify", 32'h1, {31'h0, blockNotify});
    expQ.push_back(6'h01);
    expQ.push_back(6'h04);
    blkSet <= 1'b0;
    tk(2);
    chk("blocked start", 32'h0001, {16'h0, blockedOut, startOut});
    expQ.push_back(6'h00);
    freqSet <= 17'h0C350;
    blkSet <= 1'b1;
    tk(2);
    expQ.push_back(6'h05);
    freqSet <= 17'h0C92C;
    tk(3);
    chk("blocked start", 32'h0100, {16'h0, blockedOut, startOut});
    expQ.push_back(6'h04);
    freqSet <= 17'h0C350;
    blkSet <= 1'b0;
    tk(2);
    // under stage, event selection, default delay
    wr(A_EVSEL, 32'h1);
    wr(11'h440, 32'h1);
    freqSet <= 17'h0BF67;
    wait_hi(0, 4);
    expQ.push_back(6'h20);
    freqSet <= 17'h0C350;
    tk(2);
    wr(A_EVSEL, 32'h3F);
    expQ.push_back(6'h21);
    expQ.push_back(6'h23);
    freqSet <= 17'h0BF67;
    wait_hi(0, 4);
    tk(21);
    chk("trip", 32'h1, {31'h0, tripOut[4]});
    rd("status", A_STAT, 32'h00010200);
    freqSet <= 17'h0BF7B;
    tk(2);
    chk("trip", 32'h1, {31'h0, tripOut[4]});
    expQ.push_back(6'h20);
    expQ.push_back(6'h22);
    freqSet <= 17'h0BF7C;
    tk(2);
    chk("outputs", 32'h0, {16'h0, tripOut, startOut});
    // node switched off
    wr(A_CTRL, 32'h500);
    freqSet <= 17'h0BB80;
    tk(3);
    chk("start", 32'h0, {24'h0, startOut});
    rd("status", A_STAT, 32'h00050000);
    freqSet <= 17'h0C350;
    tk(2);
    wr(A_CTRL, 32'h100);
    tk(2);
    // forcing: forced block, then software block stops the timer
    wr(A_CTRL, 32'h101);
    freqSet <= 17'h0C92C;
    expQ.push_back(6'h05);
    wr(A_FORCE, 32'h3);
    tk(3);
    chk("forced", 32'h0100, {16'h0, blockedOut, startOut});
    bus(1'b0, A_REMAIN, xs());
    chk("remain", 32'h1, {31'h0, q != 32'h0 && q < 32'h64});
    wr(A_CTRL, 32'h103);
    tk(2);
    rd("remain", A_REMAIN, 32'h0);
    rd("expect", A_EXPECT, 32'h64);
    expQ.push_back(6'h01);
    expQ.push_back(6'h04);
    wr(A_CTRL, 32'h100);
    tk(2);
    expQ.push_back(6'h00);
    freqSet <= 17'(49000 + xs() % 1980);
    tk(2);
    rd("ratio", A_RATIO, 32'(freqSet) * 32'd1000 / 32'd51000);
    rd("record", A_RINFO, 32'h1);
    rd("record freq", A_RFLT, 32'h0C92C);
    wr(A_CNTSEL, 32'h1);
    rd("trip count", A_CNT, 32'h1);
    wr(A_CNTCLR, 32'h2);
    rd("trip count", A_CNT, 32'h0);
    chk("queue", 32'h0, 32'(expQ.size()));
    report_and_stop();
  end
endmodule // freq_protection_unit_tb
`default_nettype wire
